// ==== rtl/isp_pkg.sv ====
// Constants for the serial programming port: opcodes, reset values and wait times
package isp_pkg;
    // Instruction bytes
    localparam logic [7:0] OP_ENABLE       = 8'hAC;
    localparam logic [7:0] SUB_ENABLE      = 8'h53;
    localparam logic [7:0] SUB_ERASE       = 8'h80;
    localparam logic [7:0] SUB_W_LOCK      = 8'hE0;
    localparam logic [7:0] SUB_W_FUSE_LOW  = 8'hA0;
    localparam logic [7:0] SUB_W_FUSE_HIGH = 8'hA8;
    localparam logic [7:0] SUB_W_FUSE_EXT  = 8'hA4;
    localparam logic [7:0] OP_POLL         = 8'hF0;
    localparam logic [7:0] OP_LOAD_LOW     = 8'h40;
    localparam logic [7:0] OP_LOAD_HIGH    = 8'h48;
    localparam logic [7:0] OP_WRITE_PAGE   = 8'h4C;
    localparam logic [7:0] OP_EEP_WRITE    = 8'hC0;
    localparam logic [7:0] OP_EEP_LOAD     = 8'hC1;
    localparam logic [7:0] OP_EEP_PAGE     = 8'hC2;
    localparam logic [7:0] OP_READ_LOW     = 8'h20;
    localparam logic [7:0] OP_READ_HIGH    = 8'h28;
    localparam logic [7:0] OP_EEP_READ     = 8'hA0;
    localparam logic [7:0] OP_READ_LOCK    = 8'h58;
    localparam logic [7:0] OP_READ_FUSE    = 8'h50;
    localparam logic [7:0] OP_READ_SIG     = 8'h30;
    localparam logic [7:0] OP_READ_CAL     = 8'h38;
    localparam logic [7:0] SUB_CFG_BASE    = 8'h00;
    localparam logic [7:0] SUB_CFG_ALT     = 8'h08;
    // Erased and reset contents
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
    localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
    localparam logic [7:0]  CFG_RESET      = 8'hFF;
    // Frame layout
    localparam logic [4:0]  LAST_BIT       = 5'h1F;
    localparam logic [4:0]  BYTE2_DONE     = 5'h10;
    localparam logic [4:0]  BYTE3_DONE     = 5'h18;
    // Wait times and their cycle counts
    localparam int unsigned CLK_PERIOD_NS         = 10;
    localparam int unsigned FLASH_PAGE_WRITE_WAIT_NS = 4500000;
    localparam int unsigned EEPROM_WRITE_WAIT_NS  = 4000000;
    localparam int unsigned CHIP_ERASE_WAIT_NS    = 4000000;
    localparam int unsigned FUSE_WRITE_WAIT_NS    = 4500000;
    localparam int unsigned FLASH_PAGE_WRITE_WAIT_CYC = FLASH_PAGE_WRITE_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned EEPROM_WRITE_WAIT_CYC = EEPROM_WRITE_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned CHIP_ERASE_WAIT_CYC   = CHIP_ERASE_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned FUSE_WRITE_WAIT_CYC   = FUSE_WRITE_WAIT_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SWEEP = 3'b010,
        ST_WAIT  = 3'b100
    } busy_state_t;

    typedef enum logic [2:0] {
        SW_ERASE = 3'b001,
        SW_FLASH = 3'b010,
        SW_EEP   = 3'b100
    } sweep_kind_t;
endpackage

// ==== rtl/isp_port.sv ====
// Serial in-system programming port: frame decoder, page buffers and write engine
// Overview of operation
// - Program, erase and load instructions are ignored until programming is enabled.
// - Incoming bits are taken from the data input on each rising serial clock.
// - Outgoing bits change on each falling serial clock.
// - Enable is AC 53 00 00; second byte echoes during the third.
// - Opcodes 40 and 48 load low and high page-buffer bytes by word.
// - Opcode 4C commits the page buffer to the addressed flash page.
// - Opcode C0 erases and writes one EEPROM byte as one timed operation.
// - C1 loads EEPROM page bytes, C2 commits; unloaded bytes stay unchanged.
// - AC 80 sets every flash and EEPROM location to all ones.
// - Opcode F0 returns a fourth byte with bit 0 set while busy.
// - Opcodes 20, 28 and A0 return flash low, high and EEPROM bytes.
// - 58/50 with 00/08 return lock and fuse bytes; 30 and 38 too.
// - AC with E0, A0, A8, A4 writes lock, low, high, extended fuses.
// - Flash addresses are word addresses; loads may come in any order.
`timescale 1ns/1ps
module isp_port #(
    parameter int          FA        = 13,   // Flash word address bits
    parameter int          PW        = 5,    // Word index bits within a flash page
    parameter int          EA        = 6,    // EEPROM address bits
    parameter int          EPW       = 2,    // Byte index bits within an EEPROM page
    parameter int          TW        = 20,   // Busy timer width
    parameter int unsigned FLASH_PAGE_WRITE_WAIT = isp_pkg::FLASH_PAGE_WRITE_WAIT_CYC,
    parameter int unsigned EEPROM_WRITE_WAIT     = isp_pkg::EEPROM_WRITE_WAIT_CYC,
    parameter int unsigned CHIP_ERASE_WAIT       = isp_pkg::CHIP_ERASE_WAIT_CYC,
    parameter int unsigned FUSE_WRITE_WAIT       = isp_pkg::FUSE_WRITE_WAIT_CYC,
    parameter logic [7:0]  SIG0      = 8'h5A,  // Arbitrary value
    parameter logic [7:0]  SIG1      = 8'hA5,  // Arbitrary value
    parameter logic [7:0]  SIG2      = 8'h3C,  // Arbitrary value
    parameter logic [7:0]  CAL_BYTE  = 8'h80
) (
    input  wire logic       clock_i,                   // System clock
    input  wire logic       rst_i,                     // Synchronous reset, active high
    input  wire logic       ext_reset_n_i,             // Device reset pin, low = session
    input  wire logic       sck_i,                     // Serial clock pin
    input  wire logic       mosi_i,                    // Serial data in
    output logic            miso_o,                    // Serial data out
    output logic            operation_pending_flag_o,  // Write or erase in progress
    output logic            prog_enabled_o,            // Programming enabled
    output logic [7:0]      lock_bits_o,               // Lock byte
    output logic [7:0]      fuse_low_o,                // Low fuse byte
    output logic [7:0]      fuse_high_o,               // High fuse byte
    output logic [7:0]      fuse_ext_o                 // Extended fuse byte
);
    localparam int PAGE_WORDS = 2**PW;
    localparam int EPAGE      = 2**EPW;

    nv_port_if #(.AW(FA), .DW(16), .BW(2)) flash_port ();
    nv_port_if #(.AW(EA), .DW(8),  .BW(1)) eep_port ();

    nv_array #(.AW(FA), .DW(16), .BW(2)) u_flash (.clock_i(clock_i), .port(flash_port));
    nv_array #(.AW(EA), .DW(8),  .BW(1)) u_eep   (.clock_i(clock_i), .port(eep_port));

    logic sck_s1, sck_s2, sck_d, mosi_s1, mosi_s2, rstn_s1, rstn_s2;
    logic [31:0]            shift, next_shift;
    logic [4:0]             bitcnt, next_bitcnt;
    logic [7:0]             tx, next_tx;
    logic                   next_miso, next_enabled;
    logic [7:0]             next_lock, next_flow, next_fhigh, next_fext;
    logic [15:0]            fbuf [PAGE_WORDS];
    logic [15:0]            next_fbuf [PAGE_WORDS];
    logic [7:0]             ebuf [EPAGE];
    logic [7:0]             next_ebuf [EPAGE];
    logic [EPAGE-1:0]       emask, next_emask;
    logic [FA-PW-1:0]       fpage, next_fpage;
    logic [EA-EPW-1:0]      epage, next_epage;
    logic [FA-1:0]          sweep_idx, next_sweep_idx;
    logic [TW-1:0]          timer, next_timer;
    isp_pkg::busy_state_t   state, next_state;
    isp_pkg::sweep_kind_t   kind, next_kind;
    logic                   sck_rise, sck_fall, in_session, busy;
    logic [31:0]            full;
    logic [7:0]             c1, c2, c3, c4, reply, read_result;
    logic                   sweep_last;

    assign sck_rise   = sck_s2 & ~sck_d;
    assign sck_fall   = ~sck_s2 & sck_d;
    assign in_session = ~rstn_s2;
    assign busy       = (state != isp_pkg::ST_IDLE);

    // Memory ports: sweep address while busy with their own write or an erase, else the address bytes of the frame
    always_comb begin
        flash_port.we    = (state == isp_pkg::ST_SWEEP) && (kind != isp_pkg::SW_EEP);
        flash_port.be    = 2'h3;
        flash_port.wdata = (kind == isp_pkg::SW_FLASH) ? fbuf[sweep_idx[PW-1:0]]
                                                       : isp_pkg::ERASED_WORD;
        flash_port.addr  = (kind == isp_pkg::SW_FLASH && busy) ?
                           {fpage, sweep_idx[PW-1:0]} :
                           (kind == isp_pkg::SW_ERASE && busy) ? sweep_idx :
                           shift[FA-1:0];
        eep_port.we      = (state == isp_pkg::ST_SWEEP) &&
                           ((kind == isp_pkg::SW_ERASE) ||
                            (kind == isp_pkg::SW_EEP && emask[sweep_idx[EPW-1:0]]));
        eep_port.be      = 1'h1;
        eep_port.wdata   = (kind == isp_pkg::SW_EEP) ? ebuf[sweep_idx[EPW-1:0]]
                                                     : isp_pkg::ERASED_BYTE;
        eep_port.addr    = (kind == isp_pkg::SW_EEP && busy) ? {epage, sweep_idx[EPW-1:0]} :
                           (kind == isp_pkg::SW_ERASE && busy) ? sweep_idx[EA-1:0] :
                           shift[EA-1:0];
    end

    // Fourth-byte answer of read and poll instructions, decoded from bytes 1 to 3
    always_comb begin
        read_result = 8'h00;
        case (shift[23:16])
            isp_pkg::OP_POLL:      read_result = {7'h00, busy};
            isp_pkg::OP_READ_LOW:  read_result = flash_port.rdata[7:0];
            isp_pkg::OP_READ_HIGH: read_result = flash_port.rdata[15:8];
            isp_pkg::OP_EEP_READ:  read_result = eep_port.rdata;
            isp_pkg::OP_READ_LOCK: read_result = (shift[15:8] == isp_pkg::SUB_CFG_ALT) ?
                                                 fuse_high_o : lock_bits_o;
            isp_pkg::OP_READ_FUSE: read_result = (shift[15:8] == isp_pkg::SUB_CFG_ALT) ?
                                                 fuse_ext_o : fuse_low_o;
            isp_pkg::OP_READ_SIG:  read_result = (shift[1:0] == 2'h0) ? SIG0 :
                                                 (shift[1:0] == 2'h1) ? SIG1 : SIG2;
            isp_pkg::OP_READ_CAL:  read_result = CAL_BYTE;
            default:               read_result = shift[7:0];
        endcase
        // Byte 1 returns 00 and bytes 2 and 3 echo the previous one, so 0x53 returns during byte 3
        if (bitcnt == isp_pkg::BYTE3_DONE && prog_enabled_o) begin
            reply = read_result;
        end else if (bitcnt == 5'h00) begin
            reply = 8'h00;
        end else begin
            reply = shift[7:0];
        end
    end

    always_comb begin
        next_shift     = shift;
        next_bitcnt    = bitcnt;
        next_tx        = tx;
        next_miso      = miso_o;
        next_enabled   = prog_enabled_o;
        next_lock      = lock_bits_o;
        next_flow      = fuse_low_o;
        next_fhigh     = fuse_high_o;
        next_fext      = fuse_ext_o;
        next_fbuf      = fbuf;
        next_ebuf      = ebuf;
        next_emask     = emask;
        next_fpage     = fpage;
        next_epage     = epage;
        next_sweep_idx = sweep_idx;
        next_timer     = timer;
        next_state     = state;
        next_kind      = kind;
        full = {shift[30:0], mosi_s2};
        c1 = full[31:24];
        c2 = full[23:16];
        c3 = full[15:8];
        c4 = full[7:0];
        sweep_last = (kind == isp_pkg::SW_FLASH) ? (&sweep_idx[PW-1:0]) :
                     (kind == isp_pkg::SW_EEP)   ? (&sweep_idx[EPW-1:0]) : (&sweep_idx);

        // Timed operations keep running even if the session ends
        if (timer != '0) begin
            next_timer = timer - TW'(1);
        end
        case (state)
            isp_pkg::ST_IDLE: begin
                next_sweep_idx = '0;
            end
            isp_pkg::ST_SWEEP: begin
                next_sweep_idx = sweep_idx + FA'(1);
                if (sweep_last) begin
                    next_state = isp_pkg::ST_WAIT;
                    if (kind == isp_pkg::SW_FLASH) begin
                        for (int i = 0; i < PAGE_WORDS; i++) begin
                            next_fbuf[i] = isp_pkg::ERASED_WORD;
                        end
                    end
                    if (kind == isp_pkg::SW_EEP) begin
                        next_emask = '0;
                    end
                end
            end
            isp_pkg::ST_WAIT: begin
                if (timer <= TW'(1)) begin
                    next_state = isp_pkg::ST_IDLE;
                end
            end
            default: next_state = isp_pkg::ST_IDLE;
        endcase

        if (!in_session) begin
            next_bitcnt  = 5'h00;
            next_enabled = 1'b0;
            next_miso    = 1'b0;
            next_tx      = 8'h00;
        end else begin
            if (sck_rise) begin
                next_shift  = full;
                next_bitcnt = bitcnt + 5'h01;
            end
            if (sck_fall) begin
                if (bitcnt[2:0] == 3'h0) begin
                    next_miso = reply[7];
                    next_tx   = {reply[6:0], 1'b0};
                end else begin
                    next_miso = tx[7];
                    next_tx   = {tx[6:0], 1'b0};
                end
            end
            if (sck_rise && bitcnt == isp_pkg::LAST_BIT) begin
                if (c1 == isp_pkg::OP_ENABLE && c2 == isp_pkg::SUB_ENABLE) begin
                    next_enabled = 1'b1;
                end else if (prog_enabled_o && !busy) begin
                    case (c1)
                        isp_pkg::OP_ENABLE: begin
                            if (c2 == isp_pkg::SUB_ERASE) begin
                                next_state = isp_pkg::ST_SWEEP;
                                next_kind  = isp_pkg::SW_ERASE;
                                next_timer = TW'(CHIP_ERASE_WAIT);
                                next_lock  = isp_pkg::CFG_RESET;
                            end else if (c2 == isp_pkg::SUB_W_LOCK ||
                                         c2 == isp_pkg::SUB_W_FUSE_LOW ||
                                         c2 == isp_pkg::SUB_W_FUSE_HIGH ||
                                         c2 == isp_pkg::SUB_W_FUSE_EXT) begin
                                next_state = isp_pkg::ST_WAIT;
                                next_timer = TW'(FUSE_WRITE_WAIT);
                                // Lock bits only become programmed; erase clears them
                                if (c2 == isp_pkg::SUB_W_LOCK)      next_lock  = lock_bits_o & c4;
                                if (c2 == isp_pkg::SUB_W_FUSE_LOW)  next_flow  = c4;
                                if (c2 == isp_pkg::SUB_W_FUSE_HIGH) next_fhigh = c4;
                                if (c2 == isp_pkg::SUB_W_FUSE_EXT)  next_fext  = c4;
                            end
                        end
                        isp_pkg::OP_LOAD_LOW: begin
                            next_fbuf[c3[PW-1:0]][7:0] = c4;
                        end
                        isp_pkg::OP_LOAD_HIGH: begin
                            next_fbuf[c3[PW-1:0]][15:8] = c4;
                        end
                        isp_pkg::OP_WRITE_PAGE: begin
                            next_fpage = full[FA+7:PW+8];
                            next_state = isp_pkg::ST_SWEEP;
                            next_kind  = isp_pkg::SW_FLASH;
                            next_timer = TW'(FLASH_PAGE_WRITE_WAIT);
                        end
                        isp_pkg::OP_EEP_LOAD: begin
                            next_ebuf[c3[EPW-1:0]]  = c4;
                            next_emask[c3[EPW-1:0]] = 1'b1;
                        end
                        isp_pkg::OP_EEP_PAGE, isp_pkg::OP_EEP_WRITE: begin
                            next_epage = c3[EA-1:EPW];
                            next_state = isp_pkg::ST_SWEEP;
                            next_kind  = isp_pkg::SW_EEP;
                            next_timer = TW'(EEPROM_WRITE_WAIT);
                            // Single byte write rides the page path with one byte marked
                            if (c1 == isp_pkg::OP_EEP_WRITE) begin
                                next_emask = '0;
                                next_emask[c3[EPW-1:0]] = 1'b1;
                                next_ebuf[c3[EPW-1:0]]  = c4;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        sck_s1  <= sck_i;
        sck_s2  <= sck_s1;
        mosi_s1 <= mosi_i;
        mosi_s2 <= mosi_s1;
        rstn_s1 <= ext_reset_n_i;
        rstn_s2 <= rstn_s1;
        ebuf    <= next_ebuf;
        if (rst_i) begin
            fbuf                     <= '{default: isp_pkg::ERASED_WORD};
            sck_d                    <= 1'b0;
            shift                    <= '0;
            bitcnt                   <= 5'h00;
            tx                       <= 8'h00;
            miso_o                   <= 1'b0;
            prog_enabled_o           <= 1'b0;
            lock_bits_o              <= isp_pkg::CFG_RESET;
            fuse_low_o               <= isp_pkg::CFG_RESET;
            fuse_high_o              <= isp_pkg::CFG_RESET;
            fuse_ext_o               <= isp_pkg::CFG_RESET;
            emask                    <= '0;
            fpage                    <= '0;
            epage                    <= '0;
            sweep_idx                <= '0;
            timer                    <= '0;
            state                    <= isp_pkg::ST_IDLE;
            kind                     <= isp_pkg::SW_EEP;
            operation_pending_flag_o <= 1'b0;
        end else begin
            sck_d                    <= sck_s2;
            fbuf                     <= next_fbuf;
            shift                    <= next_shift;
            bitcnt                   <= next_bitcnt;
            tx                       <= next_tx;
            miso_o                   <= next_miso;
            prog_enabled_o           <= next_enabled;
            lock_bits_o              <= next_lock;
            fuse_low_o               <= next_flow;
            fuse_high_o              <= next_fhigh;
            fuse_ext_o               <= next_fext;
            emask                    <= next_emask;
            fpage                    <= next_fpage;
            epage                    <= next_epage;
            sweep_idx                <= next_sweep_idx;
            timer                    <= next_timer;
            state                    <= next_state;
            kind                     <= next_kind;
            operation_pending_flag_o <= (next_state != isp_pkg::ST_IDLE);
        end
    end
endmodule

// ==== rtl/nv_array.sv ====
// Byte-writable memory array with registered read data
`timescale 1ns/1ps
module nv_array #(
    parameter int AW = 8,
    parameter int DW = 8,
    parameter int BW = 1
) (
    input  wire logic clock_i,   // System clock
    nv_port_if.array  port       // Access port
);
    logic [DW-1:0] mem [2**AW];

    // Contents are nonvolatile, so nothing here is reset
    always_ff @(posedge clock_i) begin
        for (int b = 0; b < BW; b++) begin
            if (port.we && port.be[b]) begin
                mem[port.addr][b*8 +: 8] <= port.wdata[b*8 +: 8];
            end
        end
        port.rdata <= mem[port.addr];
    end
endmodule

// ==== rtl/nv_port_if.sv ====
// Port bundle between the programming engine and a memory array
`timescale 1ns/1ps
interface nv_port_if #(
    parameter int AW = 8,
    parameter int DW = 8,
    parameter int BW = 1
) ();
    logic          we;
    logic [BW-1:0] be;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport array (input we, input be, input addr, input wdata, output rdata);
    modport user  (output we, output be, output addr, output wdata, input rdata);
endinterface

// ==== tb/isp_port_chk.sv ====
// Concurrent checks on the serial programming port
`timescale 1ns/1ps
module isp_port_chk (
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       ext_reset_n_i,
    input wire logic       sck_i,
    input wire logic       mosi_i,
    input wire logic       miso_o,
    input wire logic       operation_pending_flag_o,
    input wire logic       prog_enabled_o,
    input wire logic [7:0] lock_bits_o,
    input wire logic [7:0] fuse_low_o,
    input wire logic [7:0] fuse_high_o,
    input wire logic [7:0] fuse_ext_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_pend_start; $rose(operation_pending_flag_o); endsequence
    sequence s_session_end; $rose(ext_reset_n_i); endsequence
    chk_reset_cfg: assert property ($fell(rst_i) |->
        {lock_bits_o, fuse_low_o, fuse_high_o, fuse_ext_o} == {4{8'hFF}}) else $error("cfg reset");
    chk_pend_enabled: assert property (s_pend_start |-> prog_enabled_o)
        else $error("op while disabled");
    chk_en_session: assert property ($rose(prog_enabled_o) |->
        !ext_reset_n_i && !$past(ext_reset_n_i, 4)) else $error("enable outside session");
    chk_en_clear: assert property (s_session_end |-> ##[1:6] !prog_enabled_o)
        else $error("enable kept");
    chk_miso_fall: assert property ($changed(miso_o) |-> !sck_i)
        else $error("miso moved with clock high");
    chk_pend_min: assert property (s_pend_start |-> operation_pending_flag_o [*8])
        else $error("busy too short");
    chk_pend_max: assert property (s_pend_start |-> ##[1:600] !operation_pending_flag_o)
        else $error("busy too long");
    chk_cfg_enabled: assert property ($changed({lock_bits_o, fuse_low_o, fuse_high_o,
        fuse_ext_o}) |-> prog_enabled_o) else $error("cfg changed while disabled");
endmodule
bind isp_port isp_port_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .ext_reset_n_i(ext_reset_n_i), .sck_i(sck_i), .mosi_i(mosi_i), .miso_o(miso_o),
    .operation_pending_flag_o(operation_pending_flag_o), .prog_enabled_o(prog_enabled_o),
    .lock_bits_o(lock_bits_o), .fuse_low_o(fuse_low_o), .fuse_high_o(fuse_high_o),
    .fuse_ext_o(fuse_ext_o));

// ==== tb/isp_programmer.sv ====
// Programmer model: clocks out instruction frames and collects returned bits
`timescale 1ns/1ps
module isp_programmer (
    input  wire logic clock_i,  // Timing reference
    output logic      sck_o,    // Serial clock
    output logic      mosi_o,   // Data to the port
    input  wire logic miso_i    // Data from the port
);
    initial begin
        sck_o  = 1'b0;
        mosi_o = 1'b0;
    end
    // Whole frame always, MSB first, four clocks low and high
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
        @(negedge clock_i);
        for (int i = 31; i >= 0; i--) begin
            sck_o  = 1'b0;
            mosi_o = cmd[i];
            repeat (4) @(negedge clock_i);
            sck_o = 1'b1;
            repeat (2) @(negedge clock_i);
            rsp[i] = miso_i;
            repeat (2) @(negedge clock_i);
        end
        sck_o  = 1'b0;
        mosi_o = ~mosi_o; // Released line must not show a stale bit
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Bench for the serial programming port
`timescale 1ns/1ps
module tb_top;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ext_reset_n = 1'b0;
    logic        sck, mosi, miso, pend, en;
    logic [7:0]  lock, f_lo, f_hi, f_ex;
    logic [31:0] rsp;
    int          errors = 0;
    int          cmp_count = 0;
    always #5 clock_i = ~clock_i;
    isp_port #(.FA(8), .FLASH_PAGE_WRITE_WAIT(200), .EEPROM_WRITE_WAIT(200),
               .CHIP_ERASE_WAIT(400), .FUSE_WRITE_WAIT(200),
               .SIG1(8'hC3), .CAL_BYTE(8'h96)) u_dut (
        .clock_i(clock_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n), .sck_i(sck),
        .mosi_i(mosi), .miso_o(miso), .operation_pending_flag_o(pend), .prog_enabled_o(en),
        .lock_bits_o(lock), .fuse_low_o(f_lo), .fuse_high_o(f_hi), .fuse_ext_o(f_ex));
    isp_programmer u_prog (.clock_i(clock_i), .sck_o(sck), .mosi_o(mosi), .miso_i(miso));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [31:0] cmd, input logic [7:0] exp);
        u_prog.xfer(cmd, rsp);
        check(rsp[7:0], exp);
    endtask
    task automatic wait_idle;
        int n = 0;
        do begin
            u_prog.xfer(32'hF000_0000, rsp); // Poll instead of the fixed wait
            n++;
        end while (rsp[0] !== 1'b0 && n < 8);
        check(rsp[7:0], 8'h00);
    endtask
    task automatic t_session;
        u_prog.xfer(32'hAC80_0000, rsp);
        repeat (4) @(negedge clock_i);
        check({6'h00, pend, en}, 8'h00);
        u_prog.xfer(32'hAC53_0000, rsp);
        check(rsp[23:16], 8'hAC);
        check(rsp[15:8], 8'h53);
        check({7'h00, en}, 8'h01);
        u_prog.xfer(32'hAC80_0000, rsp);
        rd(32'hF000_0000, 8'h01);
        wait_idle();
        rd(32'hA000_0500, 8'hFF);
        $display("session and erase done");
    endtask
    task automatic t_memory;
        u_prog.xfer(32'h4000_0156, rsp);
        u_prog.xfer(32'h4000_0334, rsp);
        u_prog.xfer(32'h4800_0312, rsp);
        u_prog.xfer(32'h4C00_0000, rsp);
        wait_idle();
        rd(32'h2000_0300, 8'h34);
        rd(32'h2800_0300, 8'h12);
        rd(32'h2000_0100, 8'h56);
        rd(32'h2800_0100, 8'hFF);
        u_prog.xfer(32'hC000_07A5, rsp);
        wait_idle();
        u_prog.xfer(32'hC100_013C, rsp);
        u_prog.xfer(32'hC200_0400, rsp);
        wait_idle();
        rd(32'hA000_0700, 8'hA5);
        rd(32'hA000_0500, 8'h3C);
        rd(32'hA000_0400, 8'hFF);
        $display("memory done");
    endtask
    task automatic t_config;
        logic [7:0]  sub[4] = '{8'hE0, 8'hA0, 8'hA8, 8'hA4};
        logic [15:0] rop[4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
        logic [7:0]  val[4] = '{8'hFC, 8'h62, 8'hD9, 8'hFE};
        for (int i = 0; i < 4; i++) begin
            u_prog.xfer({8'hAC, sub[i], 8'h00, val[i]}, rsp);
            wait_idle();
            rd({rop[i], 16'h0000}, val[i]);
        end
        check(lock ^ f_lo ^ f_hi ^ f_ex, 8'hFC ^ 8'h62 ^ 8'hD9 ^ 8'hFE);
        rd(32'h3000_0100, 8'hC3);
        rd(32'h3800_0000, 8'h96);
        ext_reset_n = 1'b1;
        repeat (8) @(negedge clock_i);
        check({7'h00, en}, 8'h00);
        $display("config and end done");
    endtask
    task automatic report_and_stop;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clock_i); // Power-up wait, shortened for simulation
        t_session();
        t_memory();
        t_config();
        report_and_stop();
    end
    initial begin
        #300us;
        errors++;
        report_and_stop();
    end
endmodule
